// ===== rtl/sdram_cmd_state.sv
// Command decoder, bank state machines and data path of the SDRAM device
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "sdram_cmd_map.svh"
module sdram_cmd_state (
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Command pins
    input wire logic CKE,
    input wire sdram_cmd_pkg::cmd_pins_s CMD,
    input wire logic [9:0] ADDR,
    input wire logic AUTO_PRECHARGE_BIT,
    input wire logic BANK_SELECT_BIT,
    input wire logic BYTE_MASK,
    // Data pins
    input wire logic [7:0] DQ_I,
    output logic [7:0] DQ_O,
    output logic DQ_OE,
    // Status
    output logic ILLEGAL_CMD,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O
);
    import sdram_cmd_pkg::*;

    state_s s_q;
    state_s s_d;
    cmd_e cmd;
    logic ba;
    logic legal;
    logic all_idle;
    logic issue;
    byte_t issue_data;
    logic [1:0] hit;
    logic [8:0] mask;
    logic [8:0] col;
    logic [1:0] cl_idx;
    logic [3:0] rp;
    logic [3:0] rcd;
    logic [3:0] rc;
    logic [3:0] wr;
    logic wb_req;
    logic cnt_clear;

    function automatic cmd_e decode(input cmd_pins_s p);
        cmd_e c;
        c = C_NOP;
        if (p.chip_select_n) begin
            c = C_DESELECT;
        end else begin
            case ({p.row_strobe_n, p.column_strobe_n, p.write_strobe_n})
                3'b111: c = C_NOP;
                3'b110: c = C_BURST_STOP;
                3'b101: c = C_READ;
                3'b100: c = C_WRITE;
                3'b011: c = C_ACTIVATE;
                3'b010: c = C_PRECHARGE;
                3'b001: c = C_REFRESH;
                3'b000: c = C_MODE_SET;
                default: c = C_NOP;
            endcase
        end
        return c;
    endfunction : decode

    function automatic bank_s enter(input bank_e st, input logic [3:0] n);
        bank_s b;
        b.st = st;
        b.timer = n;
        return b;
    endfunction : enter

    // Burst length minus one; reserved codes fall back to single words
    function automatic logic [8:0] bl_mask(input logic [6:0] m);
        logic [8:0] r;
        case (m[2:0])
            3'h1: r = 9'h001;
            3'h2: r = 9'h003;
            3'h3: r = 9'h007;
            3'h7: r = m[`MODE_TYPE_BIT] ? 9'h000 : 9'h1FF;
            default: r = 9'h000;
        endcase
        return r;
    endfunction : bl_mask

    function automatic logic [8:0] burst_addr(input logic [8:0] start,
            input logic [8:0] idx, input logic [8:0] m, input logic inter);
        logic [8:0] lo;
        lo = inter ? (start ^ idx) : 9'(start + idx);
        return (start & ~m) | (lo & m);
    endfunction : burst_addr

    function automatic bank_s finish(input logic w, input logic ap,
            input logic [3:0] n_wr, input logic [3:0] n_rp);
        bank_s b;
        if (!ap) begin
            b = enter(B_ACTIVE, 4'h0);
        end else if (w) begin
            b = enter(B_WRITE_RECOVERY, n_wr);
        end else begin
            b = enter(B_PRECHARGING, n_rp);
        end
        return b;
    endfunction : finish

    assign cmd = decode(CMD);
    assign DQ_O = s_q.dq_o;
    assign DQ_OE = s_q.dq_oe;
    assign ILLEGAL_CMD = s_q.illegal;
    assign WB_DAT_O = s_q.wb_dat;
    assign WB_ACK_O = s_q.ack;

    always_comb begin
        s_d = s_q;
        s_d.illegal = 1'b0;
        s_d.cke_q = CKE;
        legal = 1'b1;
        issue = 1'b0;
        issue_data = 8'h00;
        hit = 2'b00;
        col = 9'h000;
        ba = BANK_SELECT_BIT;
        mask = bl_mask(s_q.mode);
        rp = s_q.timing[`TIM_PRECHARGE_LSB +: 4];
        rcd = s_q.timing[`TIM_ACTIVATE_LSB +: 4];
        rc = s_q.timing[`TIM_ROW_CYCLE_LSB +: 4];
        wr = s_q.timing[`TIM_WRITE_RECOVERY_LSB +: 4];
        case (s_q.mode[`MODE_LATENCY_LSB +: 3])
            3'h1: cl_idx = 2'd0;
            3'h2: cl_idx = 2'd1;
            default: cl_idx = 2'd2;
        endcase
        all_idle = (s_q.bank[0].st == B_IDLE) && (s_q.bank[1].st == B_IDLE);
        case (s_q.pwr)
            P_POWER_DOWN, P_SELF_REFRESH: begin
                // Held while the gate stays low; a rise leaves for idle
                if (CKE) begin
                    s_d.pwr = P_NORMAL;
                    legal = (cmd == C_NOP) || (cmd == C_DESELECT);
                end
            end
            default: begin
                if (!s_q.cke_q) begin
                    // Suspended cycle: bank, burst and data state hold; cke_q, the illegal flag and the Wishbone side still update
                    s_d.cke_q = CKE;
                end else if (!CKE && all_idle && !s_q.burst_on) begin
                    // Output pipe is dropped so the bus is free while asleep
                    s_d.rd_valid = 3'b000;
                    s_d.dq_oe = 1'b0;
                    if (cmd == C_NOP || cmd == C_DESELECT) begin
                        s_d.pwr = P_POWER_DOWN;
                    end else if (cmd == C_REFRESH) begin
                        s_d.pwr = P_SELF_REFRESH;
                    end else begin
                        legal = 1'b0;
                    end
                end else begin
                    // Timed bank states run down first
                    for (int i = 0; i < 2; i++) begin
                        if (s_q.bank[i].timer <= 4'h1) begin
                            case (s_q.bank[i].st)
                                B_ACTIVATING: s_d.bank[i] = enter(B_ACTIVE, 4'h0);
                                B_WRITE_RECOVERY:
                                    s_d.bank[i] = enter(B_PRECHARGING, rp);
                                B_PRECHARGING, B_REFRESH, B_MODE_ACCESS:
                                    s_d.bank[i] = enter(B_IDLE, 4'h0);
                                default: s_d.bank[i].timer = 4'h0;
                            endcase
                        end else begin
                            s_d.bank[i].timer = s_q.bank[i].timer - 4'h1;
                        end
                    end
                    case (cmd)
                        C_ACTIVATE: begin
                            if (s_d.bank[ba].st == B_IDLE) begin
                                s_d.bank[ba] = enter(B_ACTIVATING, rcd);
                            end else begin
                                legal = 1'b0;
                            end
                        end
                        C_READ, C_WRITE: begin
                            if (s_d.bank[ba].st inside {B_ACTIVE, B_READ,
                                    B_WRITE}) begin
                                if (s_q.burst_on) begin
                                    s_d.bank[s_q.burst_bank] = finish(
                                        s_q.burst_wr, s_q.burst_ap, wr, rp);
                                end
                                if (AUTO_PRECHARGE_BIT) begin
                                    s_d.bank[ba] = enter((cmd == C_WRITE) ?
                                        B_WRITE_AP : B_READ_AP, 4'h0);
                                end else begin
                                    s_d.bank[ba] = enter((cmd == C_WRITE) ?
                                        B_WRITE : B_READ, 4'h0);
                                end
                                s_d.burst_on = 1'b1;
                                s_d.burst_wr = (cmd == C_WRITE);
                                s_d.burst_ap = AUTO_PRECHARGE_BIT;
                                s_d.burst_bank = ba;
                                s_d.burst_start = ADDR[8:0];
                                s_d.burst_idx = 9'h000;
                                s_d.burst_left = mask;
                            end else begin
                                legal = 1'b0;
                            end
                        end
                        C_BURST_STOP: begin
                            if (s_q.burst_on && s_q.burst_ap) begin
                                legal = 1'b0;
                            end else if (s_q.burst_on) begin
                                s_d.burst_on = 1'b0;
                                s_d.bank[s_q.burst_bank] = enter(B_ACTIVE, 4'h0);
                            end
                        end
                        C_PRECHARGE: begin
                            hit = AUTO_PRECHARGE_BIT ? 2'b11 :
                                (ba ? 2'b10 : 2'b01);
                            for (int i = 0; i < 2; i++) begin
                                if (hit[i] && !(s_d.bank[i].st inside {B_IDLE,
                                        B_PRECHARGING, B_ACTIVE, B_READ,
                                        B_WRITE})) begin
                                    legal = 1'b0;
                                end
                            end
                            if (legal) begin
                                for (int i = 0; i < 2; i++) begin
                                    if (hit[i] && s_d.bank[i].st inside
                                            {B_ACTIVE, B_READ, B_WRITE}) begin
                                        s_d.bank[i] = enter(B_PRECHARGING, rp);
                                    end
                                end
                                // Words already in the read pipe still leave
                                if (s_q.burst_on && hit[s_q.burst_bank]) begin
                                    s_d.burst_on = 1'b0;
                                end
                            end
                        end
                        C_REFRESH: begin
                            if (s_d.bank[0].st == B_IDLE &&
                                    s_d.bank[1].st == B_IDLE) begin
                                s_d.bank[0] = enter(B_REFRESH, rc);
                                s_d.bank[1] = enter(B_REFRESH, rc);
                            end else begin
                                legal = 1'b0;
                            end
                        end
                        C_MODE_SET: begin
                            if (s_d.bank[0].st == B_IDLE &&
                                    s_d.bank[1].st == B_IDLE &&
                                    !BANK_SELECT_BIT) begin
                                s_d.mode = ADDR[6:0];
                                s_d.bank[0] = enter(B_MODE_ACCESS, `MODE_SET_CYC);
                                s_d.bank[1] = enter(B_MODE_ACCESS, `MODE_SET_CYC);
                            end else begin
                                legal = 1'b0;
                            end
                        end
                        default: begin
                            // No-op and deselect let any burst run on
                            legal = 1'b1;
                        end
                    endcase
                    // One word of the live burst per enabled cycle
                    if (s_d.burst_on) begin
                        col = burst_addr(s_d.burst_start, s_d.burst_idx,
                            mask, s_q.mode[`MODE_TYPE_BIT]);
                        if (s_d.burst_wr) begin
                            if (!BYTE_MASK) begin
                                s_d.mem[s_d.burst_bank][col[STORE_COL_BITS - 1:0]]
                                    = DQ_I;
                            end
                        end else begin
                            issue = 1'b1;
                            issue_data = s_q.mem[s_d.burst_bank]
                                [col[STORE_COL_BITS - 1:0]];
                        end
                        if (s_d.burst_left == 9'h000) begin
                            s_d.burst_on = 1'b0;
                            s_d.bank[s_d.burst_bank] = finish(s_d.burst_wr,
                                s_d.burst_ap, wr, rp);
                        end else begin
                            s_d.burst_idx = s_d.burst_idx + 9'h001;
                            s_d.burst_left = s_d.burst_left - 9'h001;
                        end
                    end
                    // Read latency pipe; the mask lags two edges
                    s_d.rd_valid = {s_q.rd_valid[1:0], issue};
                    s_d.rd_data = {s_q.rd_data[1:0], issue_data};
                    s_d.dqm1 = BYTE_MASK;
                    s_d.dqm2 = s_q.dqm1;
                    s_d.dq_o = s_d.rd_data[cl_idx];
                    s_d.dq_oe = s_d.rd_valid[cl_idx] && !s_d.dqm2;
                end
            end
        endcase
        s_d.illegal = !legal;
        // Wishbone slave: one wait state, ack for one cycle
        wb_req = WB_CYC_I && WB_STB_I;
        s_d.ack = wb_req && !s_q.ack;
        cnt_clear = 1'b0;
        if (wb_req && !s_q.ack) begin
            s_d.wb_dat = 32'h0000_0000;
            case (WB_ADR_I)
                `REG_STATUS: begin
                    s_d.wb_dat[`ST_BANK0_LSB +: 4] = s_q.bank[0].st;
                    s_d.wb_dat[`ST_BANK1_LSB +: 4] = s_q.bank[1].st;
                    s_d.wb_dat[`ST_POWER_LSB +: 2] = s_q.pwr;
                    s_d.wb_dat[`ST_BURST_ON_BIT] = s_q.burst_on;
                    s_d.wb_dat[`ST_BURST_BANK_BIT] = s_q.burst_bank;
                    s_d.wb_dat[`ST_CKE_BIT] = s_q.cke_q;
                end
                `REG_MODE: s_d.wb_dat[6:0] = s_q.mode;
                `REG_TIMING: s_d.wb_dat[15:0] = s_q.timing;
                `REG_ILLEGAL_COUNT: s_d.wb_dat[15:0] = s_q.illegal_cnt;
                default: s_d.wb_dat = 32'h0000_0000;
            endcase
        end
        if (wb_req && s_q.ack && WB_WE_I) begin
            if (WB_ADR_I == `REG_TIMING) begin
                if (WB_SEL_I[0]) begin
                    s_d.timing[7:0] = WB_DAT_I[7:0];
                end
                if (WB_SEL_I[1]) begin
                    s_d.timing[15:8] = WB_DAT_I[15:8];
                end
            end
            cnt_clear = (WB_ADR_I == `REG_ILLEGAL_COUNT);
        end
        // A new illegal command outweighs a clear in the same cycle
        s_d.illegal_cnt = (cnt_clear ? 16'h0000 : s_q.illegal_cnt)
            + {15'h0000, s_d.illegal};
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            s_q <= '0;
            s_q.mode <= `MODE_RESET;
            s_q.timing <= `TIMING_RESET;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : sdram_cmd_state
`default_nettype wire

// ===== rtl/sdram_cmd_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SDRAM_CMD_MAP_SVH
`define SDRAM_CMD_MAP_SVH

`define CLK_PERIOD_NS 20
`define PRECHARGE_INTERVAL_NS 20
`define ACTIVATE_TO_COLUMN_INTERVAL_NS 20
`define ROW_CYCLE_INTERVAL_NS 70
`define WRITE_RECOVERY_NS 8
`define NS_TO_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRECHARGE_INTERVAL_CYC `NS_TO_CYC(`PRECHARGE_INTERVAL_NS)
`define ACTIVATE_TO_COLUMN_CYC `NS_TO_CYC(`ACTIVATE_TO_COLUMN_INTERVAL_NS)
`define ROW_CYCLE_INTERVAL_CYC `NS_TO_CYC(`ROW_CYCLE_INTERVAL_NS)
`define WRITE_RECOVERY_CYC `NS_TO_CYC(`WRITE_RECOVERY_NS)
`define MODE_SET_CYC 4'h2

`define MODE_LATENCY_LSB 4
`define MODE_TYPE_BIT 3
`define MODE_RESET 7'h20

`define REG_STATUS 8'h00
`define REG_MODE 8'h04
`define REG_TIMING 8'h08
`define REG_ILLEGAL_COUNT 8'h0C

`define ST_BANK0_LSB 0
`define ST_BANK1_LSB 4
`define ST_POWER_LSB 8
`define ST_BURST_ON_BIT 10
`define ST_BURST_BANK_BIT 11
`define ST_CKE_BIT 12

`define TIM_PRECHARGE_LSB 0
`define TIM_ACTIVATE_LSB 4
`define TIM_ROW_CYCLE_LSB 8
`define TIM_WRITE_RECOVERY_LSB 12
`define TIMING_RESET {4'(`WRITE_RECOVERY_CYC), 4'(`ROW_CYCLE_INTERVAL_CYC), \
    4'(`ACTIVATE_TO_COLUMN_CYC), 4'(`PRECHARGE_INTERVAL_CYC)}

`endif

// ===== rtl/sdram_cmd_pkg.sv
// Types shared by the SDRAM command logic and its bench
package sdram_cmd_pkg;

    localparam int STORE_COL_BITS = 4;

    typedef enum logic [3:0] {
        B_IDLE = 4'h0,
        B_ACTIVATING = 4'h1,
        B_ACTIVE = 4'h2,
        B_READ = 4'h3,
        B_WRITE = 4'h4,
        B_READ_AP = 4'h5,
        B_WRITE_AP = 4'h6,
        B_WRITE_RECOVERY = 4'h7,
        B_PRECHARGING = 4'h8,
        B_REFRESH = 4'h9,
        B_MODE_ACCESS = 4'hA
    } bank_e;

    typedef enum logic [1:0] {
        P_NORMAL = 2'b00,
        P_POWER_DOWN = 2'b01,
        P_SELF_REFRESH = 2'b10
    } pwr_e;

    typedef enum logic [3:0] {
        C_DESELECT = 4'h0,
        C_NOP = 4'h1,
        C_BURST_STOP = 4'h2,
        C_READ = 4'h3,
        C_WRITE = 4'h4,
        C_ACTIVATE = 4'h5,
        C_PRECHARGE = 4'h6,
        C_REFRESH = 4'h7,
        C_MODE_SET = 4'h8
    } cmd_e;

    typedef struct packed {
        logic chip_select_n;
        logic row_strobe_n;
        logic column_strobe_n;
        logic write_strobe_n;
    } cmd_pins_s;

    typedef struct packed {
        bank_e st;
        logic [3:0] timer;
    } bank_s;

    typedef logic [7:0] byte_t;

    typedef struct packed {
        logic cke_q;
        pwr_e pwr;
        bank_s [1:0] bank;
        logic [6:0] mode;
        logic burst_on;
        logic burst_wr;
        logic burst_ap;
        logic burst_bank;
        logic [8:0] burst_start;
        logic [8:0] burst_idx;
        logic [8:0] burst_left;
        logic [2:0] rd_valid;
        byte_t [2:0] rd_data;
        logic dqm1;
        logic dqm2;
        byte_t dq_o;
        logic dq_oe;
        logic illegal;
        logic [15:0] illegal_cnt;
        logic [15:0] timing;
        logic ack;
        logic [31:0] wb_dat;
        byte_t [1:0][(1 << STORE_COL_BITS) - 1:0] mem;
    } state_s;

endpackage : sdram_cmd_pkg

// ===== sim/dq_bus_model.sv
// Shared data bus between the device and the far-side controller
`timescale 1ns/1ns
`default_nettype none
module dq_bus_model (
    // Clock
    input wire logic clk,
    // Device side
    input wire logic [7:0] dev_dq,
    input wire logic dev_oe,
    // Controller side
    input wire logic [7:0] ctl_dq,
    input wire logic ctl_oe,
    // Resolved bus
    output logic [7:0] bus,
    output logic clash
);
    logic [7:0] last_q = 8'hA5;
    always_ff @(posedge clk) begin
        last_q <= bus;
    end
    // Released bus shows the inverse so stale data never matches
    always_comb begin
        bus = ~last_q;
        if (dev_oe) begin
            bus = dev_dq;
        end
        if (ctl_oe) begin
            bus = ctl_dq;
        end
    end
    assign clash = dev_oe && ctl_oe;
endmodule : dq_bus_model
`default_nettype wire

// ===== sim/sdram_cmd_asserts.sv
// Port checks on the SDRAM command block
`timescale 1ns/1ns
`default_nettype none
module sdram_cmd_asserts (
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Command side
    input wire logic CKE,
    input wire logic BYTE_MASK,
    input wire logic [7:0] DQ_O,
    input wire logic DQ_OE,
    input wire logic ILLEGAL_CMD,
    // Wishbone
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);
    wb_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
        |=> WB_ACK_O)
        else $error("no ack one cycle after request");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property ($rose(WB_ACK_O)
        |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    unmapped_zero_a: assert property (WB_ACK_O && !$past(WB_WE_I)
        && $past(WB_ADR_I) == 8'h10 |-> WB_DAT_O == 32'h0)
        else $error("unmapped read not zero");
    reset_quiet_a: assert property ($fell(SRST) |-> !DQ_OE && !WB_ACK_O
        && !ILLEGAL_CMD && DQ_O == 8'h00)
        else $error("outputs active after reset");
    read_mask_a: assert property (BYTE_MASK && CKE && $past(CKE)
        |-> ##2 !DQ_OE)
        else $error("masked read word driven");
    suspend_hold_a: assert property (!$past(CKE)
        |=> $stable(DQ_O) && $stable(DQ_OE))
        else $error("outputs moved on a suspended edge");
    suspend_quiet_a: assert property (!CKE && !$past(CKE) |=> !ILLEGAL_CMD)
        else $error("command acted on with clock gated");
    cover property ($rose(DQ_OE));
    cover property (ILLEGAL_CMD);
    cover property (WB_ACK_O && WB_WE_I);
endmodule : sdram_cmd_asserts
bind sdram_cmd_state sdram_cmd_asserts chk_u (.CLK(CLK), .SRST(SRST),
    .CKE(CKE), .BYTE_MASK(BYTE_MASK), .DQ_O(DQ_O), .DQ_OE(DQ_OE),
    .ILLEGAL_CMD(ILLEGAL_CMD), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O));
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the SDRAM command state logic
`timescale 1ns/1ns
`default_nettype none
module tb;
    import sdram_cmd_pkg::*;
    localparam cmd_pins_s NOP = 4'h7, RD = 4'h5, WR = 4'h4, ACT = 4'h3;
    localparam cmd_pins_s PRE = 4'h2, REF = 4'h1, MRS = 4'h0, STOP = 4'h6;
    logic clk = 1'b0, srst = 1'b1, cke = 1'b1, mask = 1'b0, ap = 1'b0;
    logic bs = 1'b0, ctl_oe = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    cmd_pins_s cmd = 4'h7;
    logic [9:0] addr = 10'h000;
    byte_t ctl_dq = 8'h00, d, dq_i, dq_o;
    logic dq_oe, illegal, clash, ack;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat, st;
    logic [8:0] exp_rd [4] = '{9'h1B0, 9'h111, 9'h000, 9'h1B3};
    int n_fail = 0, compares = 0;
    always #10 clk = ~clk;
    sdram_cmd_state dut_u (.CLK(clk), .SRST(srst), .CKE(cke), .CMD(cmd),
        .ADDR(addr), .AUTO_PRECHARGE_BIT(ap), .BANK_SELECT_BIT(bs),
        .BYTE_MASK(mask), .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE(dq_oe),
        .ILLEGAL_CMD(illegal), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack));
    dq_bus_model bus_u (.clk(clk), .dev_dq(dq_o), .dev_oe(dq_oe),
        .ctl_dq(ctl_dq), .ctl_oe(ctl_oe), .bus(dq_i), .clash(clash));
    task automatic summarize();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic issue(input cmd_pins_s c, input logic [9:0] a,
        input logic p, input logic b, input logic m, input logic oe,
        input byte_t v);
        @(posedge clk);
        {cmd, addr, ap, bs, mask, ctl_oe, ctl_dq} <= {c, a, p, b, m, oe, v};
    endtask : issue
    task automatic op(input cmd_pins_s c, input logic p, input logic b);
        issue(c, 10'h000, p, b, 1'b0, 1'b0, 8'h00);
    endtask : op
    task automatic nop(input int n);
        repeat (n) op(NOP, 1'b0, 1'b0);
    endtask : nop
    // Waits on ack alone; the watchdog ends a hung slave
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] v, output logic [31:0] q);
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, v};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic stat(input logic [31:0] e);
        wb(1'b0, 8'h00, 32'h0, st);
        chk(st & 32'h7FF, e);
    endtask : stat
    initial begin
        #400000;
        n_fail++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        nop(2);
        wb(1'b0, 8'h04, 32'h0, st);
        chk(st, 32'h20);
        wb(1'b0, 8'h08, 32'h0, st);
        chk(st, 32'h1411);
        wb(1'b0, 8'h10, 32'h0, st);
        chk(st, 32'h0);
        // Only the selected byte lane of the timing word may change
        sel <= 4'h1;
        wb(1'b1, 8'h08, 32'h0000_FF02, st);
        sel <= 4'hF;
        wb(1'b0, 8'h08, 32'h0, st);
        chk(st, 32'h1402);
        wb(1'b1, 8'h08, 32'h0000_1411, st);
        wb(1'b0, 8'h08, 32'h0, st);
        chk(st, 32'h1411);
        stat(32'h000);
        op(PRE, 1'b1, 1'b0);
        nop(2);
        repeat (8) begin
            op(REF, 1'b0, 1'b0);
            nop(5);
        end
        issue(MRS, 10'h022, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        nop(2);
        wb(1'b0, 8'h04, 32'h0, st);
        chk(st, 32'h22);
        op(ACT, 1'b0, 1'b0);
        // Second write cuts the first after two words
        for (int k = 0; k < 6; k++) begin
            d = k < 2 ? 8'h10 + 8'(k) : 8'hAE + 8'(k);
            issue(k == 0 || k == 2 ? WR : NOP, 10'h000, 1'b0, 1'b0,
                k == 3, 1'b1, d);
        end
        nop(3);
        op(RD, 1'b0, 1'b0);
        for (int k = 0; k < 5; k++) begin
            issue(NOP, 10'h000, 1'b0, 1'b0, k == 1, 1'b0, 8'h00);
            @(negedge clk);
            chk(32'(clash), 32'h0);
            if (k > 0) begin
                st = k == 3 ? 32'(dq_oe) : 32'({dq_oe, dq_o});
                chk(st, 32'(exp_rd[k - 1]));
            end
        end
        stat(32'h002);
        op(RD, 1'b0, 1'b0);
        op(STOP, 1'b0, 1'b0);
        stat(32'h002);
        op(RD, 1'b1, 1'b0);
        op(RD, 1'b0, 1'b0);
        op(NOP, 1'b0, 1'b0);
        @(negedge clk);
        chk(32'(illegal), 32'h1);
        nop(8);
        stat(32'h000);
        op(ACT, 1'b0, 1'b0);
        op(REF, 1'b0, 1'b0);
        op(NOP, 1'b0, 1'b0);
        @(negedge clk);
        chk(32'(illegal), 32'h1);
        wb(1'b0, 8'h0C, 32'h0, st);
        chk(st, 32'h2);
        wb(1'b1, 8'h0C, 32'h0, st);
        wb(1'b0, 8'h0C, 32'h0, st);
        chk(st, 32'h0);
        op(ACT, 1'b0, 1'b1);
        nop(2);
        op(PRE, 1'b0, 1'b1);
        nop(3);
        stat(32'h002);
        op(PRE, 1'b1, 1'b0);
        nop(3);
        stat(32'h000);
        nop(1);
        cke <= 1'b0;
        nop(4);
        stat(32'h100);
        nop(1);
        cke <= 1'b1;
        nop(3);
        stat(32'h000);
        op(REF, 1'b0, 1'b0);
        cke <= 1'b0;
        nop(4);
        stat(32'h200);
        nop(1);
        cke <= 1'b1;
        nop(3);
        stat(32'h000);
        summarize();
    end
endmodule : tb
`default_nettype wire
